/* File: hw/acs_clkdiv.sv */
`timescale 1ns/1ps
module acs_clkdiv
    import acs_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // control
    input  wire logic       run,
    input  wire logic [2:0] div,
    // tick out
    output logic            tick
);
    logic [2:0] cnt_r;

    // one tick every div+1 enabled cycles while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= ACS_DIV_ZERO;
            tick  <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_r <= ACS_DIV_ZERO;
                tick  <= 1'b0;
            end else if (cnt_r >= div) begin
                cnt_r <= ACS_DIV_ZERO;
                tick  <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 3'h1;
                tick  <= 1'b0;
            end
        end
    end
endmodule : acs_clkdiv

/* File: hw/acs_pkg.sv */
package acs_pkg;
    // register byte offsets
    localparam logic [11:0] ACS_OFF_CTRL0  = 12'h000;
    localparam logic [11:0] ACS_OFF_CTRL1  = 12'h004;
    localparam logic [11:0] ACS_OFF_STATUS = 12'h008;
    localparam logic [11:0] ACS_OFF_IFG    = 12'h00C;
    localparam logic [11:0] ACS_OFF_IMASK  = 12'h010;
    localparam logic [11:0] ACS_OFF_RESULT = 12'h014;
    localparam logic [11:0] ACS_OFF_CLKSYS = 12'h018;

    // conv_control_0 fields
    localparam int ACS_C0_SC  = 0;
    localparam int ACS_C0_ENC = 1;
    localparam int ACS_C0_ON  = 4;
    // conv_control_1 fields
    localparam int ACS_C1_SHP    = 0;
    localparam int ACS_C1_SEQ_LO = 1;
    localparam int ACS_C1_SEL_LO = 3;
    localparam int ACS_C1_DIV_LO = 5;
    // status fields
    localparam int ACS_ST_BUSY = 0;
    localparam int ACS_ST_HANG = 1;
    // flag fields
    localparam int ACS_IF_DONE = 0;
    localparam int ACS_IF_TOV  = 1;
    localparam int ACS_IF_SEQ  = 2;
    // clock_system_ctrl_4 field
    localparam int ACS_CS_SUBOFF = 0;

    localparam logic [1:0] ACS_SEQ_SINGLE     = 2'h0;
    localparam logic [1:0] ACS_SEQ_SEQUENCE   = 2'h1;
    localparam logic [1:0] ACS_SEQ_REP_SINGLE = 2'h2;
    localparam logic [1:0] ACS_SEQ_REP_SEQ    = 2'h3;
    localparam logic [1:0] ACS_CLK_SUBSYS     = 2'h3;
    localparam logic [2:0] ACS_DIV_RESET      = 3'h0;

    localparam int         ACS_FLAG_W         = 3;
    localparam int         ACS_RES_W          = 12;
    localparam logic [3:0] ACS_SAMPLE_CYCLES  = 4'h4;
    localparam logic [3:0] ACS_CONVERT_CYCLES = 4'hD;
    localparam logic [2:0] ACS_SEQ_LAST_CH    = 3'h3;
    localparam logic [3:0] ACS_CNT_ONE        = 4'h1;
    localparam logic [2:0] ACS_DIV_ZERO       = 3'h0;

    typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT} acs_state_t;
endpackage : acs_pkg

/* File: hw/acs_seq.sv */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module acs_seq
    import acs_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // converter side
    input  wire logic        timer_trig,
    input  wire logic        subsys_clk_tick,
    input  wire logic        alt_clk_tick,
    input  wire logic [11:0] sample_value,
    // status outputs
    output logic             busy,
    output logic             irq,
    output logic             result_valid,
    output logic [11:0]      result_ch_r
);
    acs_state_t              state_r;
    logic                    enc_r;
    logic                    on_r;
    logic                    shp_r;
    logic [1:0]              seq_r;
    logic [1:0]              sel_r;
    logic [2:0]              div_r;
    logic                    suboff_r;
    logic [ACS_FLAG_W-1:0]   ifg_r;
    logic [ACS_FLAG_W-1:0]   mask_r;
    logic [ACS_RES_W-1:0]    result_r;
    logic [2:0]              ch_r;
    logic [3:0]              cnt_r;
    logic                    armed_r;
    logic                    trig_m_r;
    logic                    trig_s_r;
    logic                    trig_d_r;
    logic [11:0]             smp_m_r;
    logic [11:0]             smp_s_r;
    logic                    pending_r;

    logic                    wr_en;
    logic                    rd_en;
    logic                    mapped;
    logic                    wr_c0;
    logic                    wr_c1;
    logic                    timer_edge;
    logic                    sw_start;
    logic                    start_req;
    logic                    conv_tick;
    logic                    div_tick;
    logic                    div_hold;
    logic                    done_evt;
    logic                    tov_evt;
    logic                    seq_end_evt;
    logic                    more;
    logic [ACS_FLAG_W-1:0]   set_vec;
    logic [ACS_FLAG_W-1:0]   clr_vec;
    logic [31:0]             rd_mux;

    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    assign mapped = (paddr == ACS_OFF_CTRL0) || (paddr == ACS_OFF_CTRL1) ||
                    (paddr == ACS_OFF_STATUS) || (paddr == ACS_OFF_IFG) ||
                    (paddr == ACS_OFF_IMASK) || (paddr == ACS_OFF_RESULT) ||
                    (paddr == ACS_OFF_CLKSYS);
    assign wr_c0  = wr_en && pstrb[0] && (paddr == ACS_OFF_CTRL0);
    assign wr_c1  = wr_en && pstrb[0] && (paddr == ACS_OFF_CTRL1) && !enc_r;

    // trigger and sample inputs pass two flip-flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_m_r <= 1'b0;
            trig_s_r <= 1'b0;
            trig_d_r <= 1'b0;
            smp_m_r  <= 12'h000;
            smp_s_r  <= 12'h000;
        end else if (ce) begin
            trig_m_r <= timer_trig;
            trig_s_r <= trig_m_r;
            trig_d_r <= trig_s_r;
            smp_m_r  <= sample_value;
            smp_s_r  <= smp_m_r;
        end
    end

    assign timer_edge = trig_s_r && !trig_d_r;
    assign sw_start   = wr_c0 && pwdata[ACS_C0_SC] && pwdata[ACS_C0_ENC] && !shp_r;
    // timer starts need an armed capture, armed only by setting enable
    assign start_req  = on_r && enc_r && ((shp_r && timer_edge && armed_r) || sw_start);
    // select 11 runs conversion from subsystem clock ticks
    assign conv_tick  = (sel_r == ACS_CLK_SUBSYS) ? (subsys_clk_tick && !suboff_r) : alt_clk_tick;
    // the divider holds its tick between conversion ticks; count each one once
    assign div_tick   = div_hold && conv_tick;
    assign more       = (seq_r == ACS_SEQ_REP_SINGLE) || (seq_r == ACS_SEQ_REP_SEQ) ||
                        ((seq_r == ACS_SEQ_SEQUENCE) && (ch_r != ACS_SEQ_LAST_CH));
    assign done_evt   = (state_r == ACS_CONVERT) && div_tick && (cnt_r == ACS_CNT_ONE);
    assign tov_evt    = start_req && (state_r != ACS_IDLE);
    assign seq_end_evt = done_evt && (seq_r == ACS_SEQ_SEQUENCE) && (ch_r == ACS_SEQ_LAST_CH);

    // divider counts only while a conversion runs; odd settings are safe here
    acs_clkdiv u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce && conv_tick),
        .run     (state_r != ACS_IDLE),
        .div     (div_r),
        .tick    (div_hold)
    );

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_r    <= 1'b0;
            on_r     <= 1'b0;
            shp_r    <= 1'b0;
            seq_r    <= ACS_SEQ_SINGLE;
            sel_r    <= 2'h0;
            div_r    <= ACS_DIV_RESET;
            suboff_r <= 1'b0;
            mask_r   <= '0;
        end else if (ce) begin
            if (wr_c0) begin
                on_r  <= pwdata[ACS_C0_ON];
                // enable needs power; clearing both leaves a clean idle core
                enc_r <= pwdata[ACS_C0_ENC] && pwdata[ACS_C0_ON];
            end
            if (wr_c1) begin
                shp_r <= pwdata[ACS_C1_SHP];
                seq_r <= pwdata[ACS_C1_SEQ_LO +: 2];
                sel_r <= pwdata[ACS_C1_SEL_LO +: 2];
                div_r <= pwdata[ACS_C1_DIV_LO +: 3];
            end
            if (wr_en && pstrb[0] && (paddr == ACS_OFF_CLKSYS))
                suboff_r <= pwdata[ACS_CS_SUBOFF];
            if (wr_en && pstrb[0] && (paddr == ACS_OFF_IMASK))
                mask_r <= pwdata[ACS_FLAG_W-1:0];
        end
    end

    // capture arming: a rising enable arms, other writes never do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
        end else if (ce) begin
            if (wr_c0 && !(pwdata[ACS_C0_ENC] && pwdata[ACS_C0_ON]))
                armed_r <= 1'b0;
            else if (wr_c0 && !enc_r)
                armed_r <= 1'b1;
            else if (start_req && (state_r == ACS_IDLE) && (seq_r == ACS_SEQ_SINGLE))
                armed_r <= 1'b0;
        end
    end

    // conversion state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ACS_IDLE;
            cnt_r     <= 4'h0;
            ch_r      <= 3'h0;
            pending_r <= 1'b0;
        end else if (ce) begin
            if (!on_r || !enc_r) begin
                state_r   <= ACS_IDLE;
                pending_r <= 1'b0;
                ch_r      <= 3'h0;
            end else begin
                unique case (state_r)
                    ACS_IDLE: begin
                        if (start_req || pending_r) begin
                            state_r   <= ACS_SAMPLE;
                            cnt_r     <= ACS_SAMPLE_CYCLES;
                            pending_r <= 1'b0;
                        end
                    end
                    ACS_SAMPLE: begin
                        if (start_req)
                            pending_r <= 1'b1;
                        if (div_tick) begin
                            if (cnt_r == ACS_CNT_ONE) begin
                                state_r <= ACS_CONVERT;
                                cnt_r   <= ACS_CONVERT_CYCLES;
                            end else begin
                                cnt_r <= cnt_r - 4'h1;
                            end
                        end
                    end
                    ACS_CONVERT: begin
                        if (start_req)
                            pending_r <= 1'b1;
                        if (div_tick) begin
                            if (cnt_r == ACS_CNT_ONE) begin
                                if (more) begin
                                    state_r <= ACS_SAMPLE;
                                    cnt_r   <= ACS_SAMPLE_CYCLES;
                                    ch_r    <= (ch_r == ACS_SEQ_LAST_CH) ? 3'h0 : ch_r + 3'h1;
                                end else begin
                                    state_r <= ACS_IDLE;
                                    ch_r    <= 3'h0;
                                end
                            end else begin
                                cnt_r <= cnt_r - 4'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // result capture and busy flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r     <= '0;
            result_ch_r  <= 12'h000;
            result_valid <= 1'b0;
            busy         <= 1'b0;
        end else if (ce) begin
            result_valid <= done_evt;
            if (done_evt) begin
                result_r    <= smp_s_r;
                result_ch_r <= {9'h000, ch_r};
            end
            busy <= on_r && enc_r && ((state_r != ACS_IDLE && !(done_evt && !more && !pending_r)) ||
                    start_req || pending_r);
        end
    end

    // sticky flags, write one to clear; a set wins over a clear
    assign set_vec = {seq_end_evt, tov_evt, done_evt};
    assign clr_vec = (wr_en && pstrb[0] && (paddr == ACS_OFF_IFG)) ? pwdata[ACS_FLAG_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ifg_r <= '0;
            irq   <= 1'b0;
        end else if (ce) begin
            ifg_r <= (ifg_r & ~clr_vec) | set_vec;
            irq   <= |(((ifg_r & ~clr_vec) | set_vec) & mask_r);
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ACS_OFF_CTRL0:  rd_mux[ACS_C0_ON:0] = {on_r, 2'h0, enc_r, 1'b0};
            ACS_OFF_CTRL1:  rd_mux[ACS_C1_DIV_LO+2:0] = {div_r, sel_r, seq_r, shp_r};
            ACS_OFF_STATUS: rd_mux[ACS_ST_HANG:0] = {1'b0, busy};
            ACS_OFF_IFG:    rd_mux[ACS_FLAG_W-1:0] = ifg_r;
            ACS_OFF_IMASK:  rd_mux[ACS_FLAG_W-1:0] = mask_r;
            ACS_OFF_RESULT: rd_mux[ACS_RES_W-1:0] = result_r;
            ACS_OFF_CLKSYS: rd_mux[ACS_CS_SUBOFF] = suboff_r;
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // apb: read data registered in setup, one-cycle access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_en)
                prdata <= rd_mux;
        end
    end
endmodule : acs_seq

/* File: test/acs_seq_assertions.sv */
`timescale 1ns/1ps
module acs_seq_checker
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // status
    input wire logic        busy,
    input wire logic        irq,
    input wire logic        result_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup :
        assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_one_cycle :
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_ready_has_cause :
        assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
    a_err_with_ready :
        assert property (pslverr |-> pready) else $error("error without ready");
    a_err_reads_zero :
        assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
    a_result_in_busy :
        assert property (result_valid |-> $past(busy)) else $error("result outside busy");
    a_busy_hold_min :
        assert property ($rose(busy) |=> busy[*8]) else $error("busy too short");
    a_result_one_pulse :
        assert property (result_valid |=> !result_valid) else $error("result pulse too long");
    a_quiet_reset :
        assert property ($rose(presetn) |-> !busy && !irq && !pready) else $error("outputs active after reset");

    cover property ($rose(busy));
    cover property (pready && pslverr);
    cover property (result_valid && irq);
endmodule : acs_seq_checker

/* File: test/acs_timer_model.sv */
`timescale 1ns/1ps
module acs_timer_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic shot,
    input wire logic sub_run,
    input wire logic alt_run,
    // far side outputs
    output logic     timer_trig,
    output logic     subsys_clk_tick,
    output logic     alt_clk_tick
);
    logic [2:0] len_r;
    logic [1:0] ph_r;

    // trigger held several cycles so the two-flop synchroniser cannot miss it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) len_r <= 3'h0;
        else if (shot) len_r <= 3'h6;
        else if (len_r != 3'h0) len_r <= len_r - 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ph_r <= 2'h0;
        else ph_r <= ph_r + 2'h1;
    end

    assign timer_trig      = (len_r != 3'h0);
    assign subsys_clk_tick = sub_run && ph_r[0];
    assign alt_clk_tick    = alt_run && (ph_r == 2'h3);
endmodule : acs_timer_model

/* File: test/adc_conversion_sequencer_test.sv */
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
    import acs_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        shot, timer_trig, sub_tick, alt_tick, busy, irq, result_valid, ok, e;
    logic [11:0] paddr, sample_value, res_ch;
    logic [31:0] pwdata, prdata, rdat, c1;
    int          errors, num_checks, seed;

    acs_seq dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_trig(timer_trig), .subsys_clk_tick(sub_tick),
        .alt_clk_tick(alt_tick), .sample_value(sample_value), .busy(busy), .irq(irq),
        .result_valid(result_valid), .result_ch_r(res_ch));
    acs_timer_model tmr_u (.pclk(pclk), .presetn(presetn), .shot(shot), .sub_run(1'b1),
        .alt_run(1'b0), .timer_trig(timer_trig), .subsys_clk_tick(sub_tick), .alt_clk_tick(alt_tick));

    always #5 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) errors++;
        rdat = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask : rd

    task automatic irq_is(input logic exp);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, {31'h0, exp});
    endtask : irq_is

    task automatic wait_res(input logic exp);
        ok = 1'b0;
        for (int i = 0; i < 600 && !ok; i++) begin
            @(posedge pclk);
            ok = (result_valid === 1'b1);
        end
        check({31'h0, ok}, {31'h0, exp});
    endtask : wait_res

    task automatic fire();
        shot <= 1'b1;
        @(posedge pclk);
        shot <= 1'b0;
        @(posedge pclk);
    endtask : fire

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    // longest test path is a few thousand cycles
    initial begin
        repeat (50000) @(posedge pclk);
        errors++;
        finish_test();
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        shot = 0; sample_value = 0; errors = 0; num_checks = 0; seed = 32'h10C4;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) rd(12'(4 * i), 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        check({31'h0, e}, 32'h1);
        check(rdat, 32'h0);
        $display("test reset done");
        c1 = {24'h0, 3'($random(seed)), ACS_CLK_SUBSYS, ACS_SEQ_SINGLE, 1'b0};
        sample_value <= 12'($random(seed));
        wr(ACS_OFF_CTRL1, c1);
        wr(ACS_OFF_IMASK, 32'h1);
        wr(ACS_OFF_CTRL0, 32'h12);
        wr(ACS_OFF_CTRL0, 32'h13);
        rd(ACS_OFF_STATUS, 32'h1);
        wait_res(1'b1);
        rd(ACS_OFF_RESULT, {20'h0, sample_value});
        check({20'h0, res_ch}, 32'h0);
        rd(ACS_OFF_STATUS, 32'h0);
        irq_is(1'b1);
        wr(ACS_OFF_IMASK, 32'h0);
        irq_is(1'b0);
        wr(ACS_OFF_IMASK, 32'h1);
        irq_is(1'b1);
        wr(ACS_OFF_IFG, 32'h1);
        irq_is(1'b0);
        rd(ACS_OFF_IFG, 32'h0);
        $display("test software start done");
        wr(ACS_OFF_CTRL0, 32'h10);
        wr(ACS_OFF_CTRL1, c1 | 32'h1);
        wr(ACS_OFF_CTRL0, 32'h12);
        fire();
        wait_res(1'b1);
        wr(ACS_OFF_CTRL0, 32'h12);
        fire();
        wait_res(1'b0);
        wr(ACS_OFF_CTRL0, 32'h10);
        wr(ACS_OFF_CTRL0, 32'h12);
        fire();
        wait_res(1'b1);
        $display("test timer single done");
        for (int m = 1; m < 4; m++) begin
            wr(ACS_OFF_CTRL0, 32'h10);
            wr(ACS_OFF_IFG, 32'h7);
            wr(ACS_OFF_CTRL1, c1 | 32'(m << 1));
            wr(ACS_OFF_CTRL0, 32'h12);
            wr(ACS_OFF_CTRL0, 32'h13);
            wr(ACS_OFF_CTRL0, 32'h13);
            for (int k = 0; k < 4; k++) begin
                wait_res(1'b1);
                if (m == 1) check({20'h0, res_ch}, 32'(k));
            end
            apb(1'b0, ACS_OFF_IFG, 32'h0);
            check(rdat & 32'h2, 32'h2);
            repeat (20) @(posedge pclk);
        end
        $display("test busy trigger done");
        wr(ACS_OFF_CTRL0, 32'h0);
        wr(ACS_OFF_CTRL1, c1);
        wr(ACS_OFF_CTRL0, 32'h10);
        wr(ACS_OFF_CTRL0, 32'h12);
        wr(ACS_OFF_CTRL0, 32'h13);
        wait_res(1'b1);
        $display("test recovery done");
        sample_value <= 12'($random(seed));
        wr(ACS_OFF_CTRL0, 32'h10);
        wr(ACS_OFF_CLKSYS, 32'h1);
        wr(ACS_OFF_CTRL1, 32'h58);
        wr(ACS_OFF_CTRL1, 32'h40);
        wr(ACS_OFF_CLKSYS, 32'h0);
        wr(ACS_OFF_CTRL1, 32'h38);
        wr(ACS_OFF_CTRL0, 32'h12);
        wr(ACS_OFF_CTRL0, 32'h13);
        wait_res(1'b1);
        rd(ACS_OFF_RESULT, {20'h0, sample_value});
        $display("test clock switch done");
        finish_test();
    end
endmodule : adc_conversion_sequencer_test

bind acs_seq acs_seq_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .irq(irq),
    .result_valid(result_valid));
